// File: screq_ctrl.sv
/*
 * Secondary side cycle request controller: start-up, soft-start ramp,
 * request gating and output protections.
 * Assumes analog flags qualified by outside comparators, winding_sense
 * and the rectifier gate straps arriving asynchronously from pins.
 */
// Overview of operation
// RULE_01: Wait minimum off-time after primary conduction.
// RULE_02: Start-up caps rate and current at 75 percent.
// RULE_03: Short detection masked until ramp ends.
// RULE_04: Ramp request rate linearly after handshake.
// RULE_05: Output low at retry timer means retry.
// RULE_06: Regulation aborts ramp once valley programmed.
// RULE_07: Block requests until edge or 30 us.
// RULE_08: Hot die lowers constant-current reference.
// RULE_09: Weak bleed at 2, strong at 10 percent.
// RULE_10: Feedback 20 percent high commands retry.
// RULE_11: Short at start-up stops after ramp.
// RULE_12: Deglitched feedback short stops all requests.
// RULE_13: Long output undervoltage relinquishes control.
// RULE_14: Supply overcurrent in control commands retry.
// RULE_15: Current-sense compare; grounded sense disables.
// RULE_16: Rectifier gate low when not in control.
// RULE_17: Classify gate load at 100 pF.
// RULE_18: Open gate pin stops requests.
// RULE_19: Grounded gate pin disables drive, protection.
// RULE_20: Valley windows in discontinuous mode only.
// RULE_21: Valley gating lasts 20 us after trigger.
// RULE_22: Blank edge detection about 1 us.
// RULE_23: Primary retries after long request absence.
// RULE_24: Continuous mode: gate off at request.
// RULE_25: Single request pulse when nothing inhibits.
`timescale 1ns/10ps
`include "screq_defines.svh"
module screq_ctrl #(
  parameter int OFF_MIN_CYC = 400,         // Minimum off-time
  parameter int MAX_RATE_CYC = 1500,       // Period at max_request_rate
  parameter int RAMP_CYC = 2000000,        // Soft-start ramp period
  parameter int RETRY_CYC = 12000000,      // output_retry_timer
  parameter int UV_CYC = 8000000           // undervoltage_duration
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic enable_in,              // Secondary powered up
  input wire logic handshake_done_in,      // Handshake completed
  input wire screq_pkg::screq_sense_t sense_in,
  input wire logic winding_sense_in,       // Pin, asynchronous
  input wire logic gate_cap_big_in,        // Pin load above 100 pF
  input wire logic gate_grounded_in,       // Pin strapped to ground
  input wire logic isense_grounded_in,     // Sense input grounded
  input wire logic isense_over_in,         // Sense above current_sense_level
  output logic request_out,                // One-cycle cycle request
  output logic retry_cmd_out,              // One-cycle retry command
  output logic in_control_out,
  output logic sync_rect_gate_out,
  output logic weak_bleed_out,
  output logic strong_bleed_out,
  output logic [7:0] ilim_pct_out,         // Primary current cap
  output logic [7:0] cc_ref_pct_out,       // Constant-current reference
  output logic cc_limit_out                // Constant-current throttle
);
  import screq_pkg::*;

  // ****************************************************************
  // Local constants
  // ****************************************************************
  localparam int CW = 24;
  localparam logic [CW-1:0] SOFT_CYC = CW'(`SCREQ_SOFT_CYC);
  localparam logic [CW-1:0] MAXR_CYC = CW'(MAX_RATE_CYC);
  localparam logic [CW-1:0] TMO_CYC = CW'(`SCREQ_ONTIME_TMO_CYC);
  localparam logic [CW-1:0] BLK_CYC = CW'(`SCREQ_BLANK_CYC);
  localparam logic [CW-1:0] DGL_CYC = CW'(`SCREQ_SHORT_DGL_CYC);
  localparam logic [CW-1:0] VAL_CYC = CW'(`SCREQ_VALLEY_CYC);
  localparam logic [CW-1:0] OFF_CYC = CW'(OFF_MIN_CYC);

  // Saturating increment, used by several counters
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (v == '1) ? v : v + 1'b1;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] ws_sync_reg;       // winding_sense two stages
  logic ws_last_reg;             // Previous synced sample
  logic [1:0] cap_sync_reg;
  logic [1:0] gnd_sync_reg;

  // Second stages only feed logic
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ws_sync_reg <= 2'b00;
      ws_last_reg <= 1'b0;
      cap_sync_reg <= 2'b00;
      gnd_sync_reg <= 2'b00;
    end else begin
      ws_sync_reg <= {ws_sync_reg[0], winding_sense_in};
      ws_last_reg <= ws_sync_reg[1];
      cap_sync_reg <= {cap_sync_reg[0], gate_cap_big_in};
      gnd_sync_reg <= {gnd_sync_reg[0], gate_grounded_in};
    end
  end

  logic ws_fall;
  assign ws_fall = ws_last_reg & ~ws_sync_reg[1];

  // ****************************************************************
  // Phase machine and counters
  // ****************************************************************
  screq_state_t st_reg, st_next;
  logic [CW-1:0] since_reg, since_next;   // Cycles since last request
  logic [CW-1:0] ramp_reg, ramp_next;     // Cycles into ramp
  logic [CW-1:0] on_reg, on_next;         // On-time block counter
  logic on_blk_reg, on_blk_next;          // Waiting for falling edge
  logic [CW-1:0] off_reg, off_next;       // Since primary conduction end
  logic [CW-1:0] dgl_reg, dgl_next;       // Short deglitch count
  logic [CW-1:0] val_reg, val_next;       // Valley window time left
  logic [CW-1:0] uv_reg, uv_next;         // Output low duration
  logic open_reg, open_next;              // Gate pin classified open
  logic drv_en_reg, drv_en_next;          // Rectifier drive enabled
  logic classed_reg, classed_next;        // Gate load classified
  logic prog_reg, prog_next;              // Valley programming done
  logic gate_reg, gate_next;
  logic req_reg, req_next;
  logic retry_reg, retry_next;
  logic retry_done_reg, retry_done_next;  // Retry command sent once
  logic [7:0] ilim_reg, ilim_next;
  logic [7:0] ccref_reg, ccref_next;
  logic ramp_load;
  logic retry_tmo;
  logic [CW-1:0] period;                  // Allowed request period
  logic inhibit;
  logic stop_req;
  logic in_ctl;

  // Output retry timer, started at handshake
  // RULE_05: retry timer start
  screq_timer #(
    .W(CW)
  ) u_retry_tmr (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .load_in(ramp_load),
    .value_in(CW'(RETRY_CYC)),
    .done_out(retry_tmo)
  );

  assign in_ctl = (st_reg == SCREQ_RAMP) || (st_reg == SCREQ_RUN);
  assign ramp_load = (st_reg == SCREQ_SHAKE) && handshake_done_in;

  // Period falls linearly from soft to max over the ramp
  // RULE_04: linear rate ramp
  always_comb begin
    logic [47:0] span;
    span = 48'(SOFT_CYC - MAXR_CYC) * 48'(ramp_reg) / 48'(RAMP_CYC);
    if (st_reg == SCREQ_RAMP) begin
      period = SOFT_CYC - CW'(span);
    end else begin
      period = MAXR_CYC;
    end
  end

  // Fault stop: short, open gate pin
  // RULE_11: stop after ramp
  // RULE_12: deglitched short stop
  // RULE_18: open pin stop
  assign stop_req = (dgl_reg >= DGL_CYC) || open_reg;

  // RULE_01: off-time gate
  // RULE_20: valley windows
  // RULE_21: 20 us gating
  // RULE_25: inhibit gathering
  assign inhibit = (since_reg < period) || (off_reg < OFF_CYC) ||
                   on_blk_reg || cc_limit_out ||
                   ((val_reg != '0) && !sense_in.ccm && !sense_in.valley);

  // Next state of controller
  always_comb begin
    st_next = st_reg;
    since_next = sat_inc(since_reg);
    ramp_next = ramp_reg;
    on_next = on_reg;
    on_blk_next = on_blk_reg;
    off_next = sat_inc(off_reg);
    dgl_next = dgl_reg;
    val_next = val_reg;
    uv_next = uv_reg;
    open_next = open_reg;
    drv_en_next = drv_en_reg;
    classed_next = classed_reg;
    prog_next = prog_reg;
    gate_next = gate_reg;
    req_next = 1'b0;
    retry_next = 1'b0;
    retry_done_next = retry_done_reg;
    ilim_next = `SCREQ_CC_FULL_PCT;
    ccref_next = `SCREQ_CC_FULL_PCT;
    unique case (st_reg)
      // Wait for power, classify the gate pin load
      SCREQ_IDLE: begin
        if (enable_in) begin
          // RULE_17: load classification
          // RULE_19: grounded pin disables
          classed_next = 1'b1;
          drv_en_next = !gnd_sync_reg[1];
          open_next = !gnd_sync_reg[1] && !cap_sync_reg[1];
          st_next = SCREQ_SHAKE;
        end
      end
      SCREQ_SHAKE: begin
        if (handshake_done_in) begin
          ramp_next = '0;
          st_next = SCREQ_RAMP;
        end
      end
      SCREQ_RAMP: begin
        ramp_next = sat_inc(ramp_reg);
        // RULE_03: arm at ramp end
        // RULE_06: abort on regulation
        if (ramp_reg >= CW'(RAMP_CYC - 1) ||
            (sense_in.fb_in_reg && prog_reg)) begin
          st_next = SCREQ_RUN;
        end
      end
      SCREQ_RUN: begin
        // RULE_13: give up control
        if (uv_reg >= CW'(UV_CYC)) begin
          st_next = SCREQ_STOP;
        end
      end
      SCREQ_STOP: begin
        if (!enable_in) begin
          st_next = SCREQ_IDLE;
        end
      end
      default: begin
        st_next = SCREQ_IDLE;
      end
    endcase
    // RULE_02: start-up current cap
    if (st_reg != SCREQ_RUN) begin
      ilim_next = `SCREQ_SOFT_ILIM_PCT;
    end
    // RULE_08: thermal foldback
    if (sense_in.hot_die) begin
      ccref_next = `SCREQ_CC_FOLD_PCT;
    end
    // RULE_03: short masked until run
    if (st_reg == SCREQ_RUN && sense_in.fb_short) begin
      dgl_next = sat_inc(dgl_reg);
    end else if (st_reg != SCREQ_RUN) begin
      dgl_next = '0;
    end else if (dgl_reg < DGL_CYC) begin
      dgl_next = '0;
    end
    uv_next = (in_ctl && sense_in.vout_low) ? sat_inc(uv_reg) : '0;
    // RULE_21: valley window timer
    if (sense_in.dcm_seen && !sense_in.ccm) begin
      val_next = VAL_CYC;
      prog_next = 1'b1;
    end else if (val_reg != '0) begin
      val_next = val_reg - 1'b1;
    end
    // RULE_07: on-time block
    // RULE_22: blanking
    if (on_blk_reg) begin
      on_next = sat_inc(on_reg);
      if ((ws_fall && on_reg >= BLK_CYC) || on_reg >= TMO_CYC - 1'b1) begin
        on_blk_next = 1'b0;
        off_next = '0;
      end
    end
    // Rectifier gate on at falling edge, off at end of conduction outside continuous mode
    if (ws_fall && on_blk_reg && on_reg >= BLK_CYC && drv_en_reg) begin
      gate_next = 1'b1;
    end else if (!sense_in.ccm && ws_sync_reg[1]) begin
      gate_next = 1'b0;
    end
    // RULE_25: single pulse request
    if (in_ctl && !inhibit && !stop_req && !req_reg) begin
      req_next = 1'b1;
      since_next = '0;
      on_next = '0;
      on_blk_next = 1'b1;
      // RULE_24: gate off on request
      gate_next = 1'b0;
    end
    // RULE_05: no output at timeout
    // RULE_10: overvoltage retry
    // RULE_14: supply overcurrent retry
    if (in_ctl && !retry_done_reg &&
        ((retry_tmo && sense_in.vout_low) || sense_in.fb_above_20pct ||
         sense_in.supply_ovc)) begin
      retry_next = 1'b1;
      retry_done_next = 1'b1;
      st_next = SCREQ_STOP;
    end
    // RULE_16: gate held low
    // Also on the edge that leaves control, else it lingers a cycle
    if (!in_ctl || !(st_next == SCREQ_RAMP || st_next == SCREQ_RUN)) begin
      gate_next = 1'b0;
    end
    if (st_reg == SCREQ_IDLE) begin
      retry_done_next = 1'b0;
    end
  end

  // Register the controller state
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_reg <= SCREQ_IDLE;
      since_reg <= '0;
      ramp_reg <= '0;
      on_reg <= '0;
      on_blk_reg <= 1'b0;
      off_reg <= '1;
      dgl_reg <= '0;
      val_reg <= '0;
      uv_reg <= '0;
      open_reg <= 1'b0;
      drv_en_reg <= 1'b0;
      classed_reg <= 1'b0;
      prog_reg <= 1'b0;
      gate_reg <= 1'b0;
      req_reg <= 1'b0;
      retry_reg <= 1'b0;
      retry_done_reg <= 1'b0;
      ilim_reg <= `SCREQ_SOFT_ILIM_PCT;
      ccref_reg <= `SCREQ_CC_FULL_PCT;
    end else begin
      st_reg <= st_next;
      since_reg <= since_next;
      ramp_reg <= ramp_next;
      on_reg <= on_next;
      on_blk_reg <= on_blk_next;
      off_reg <= off_next;
      dgl_reg <= dgl_next;
      val_reg <= val_next;
      uv_reg <= uv_next;
      open_reg <= open_next;
      drv_en_reg <= drv_en_next;
      classed_reg <= classed_next;
      prog_reg <= prog_next;
      gate_reg <= gate_next;
      req_reg <= req_next;
      retry_reg <= retry_next;
      retry_done_reg <= retry_done_next;
      ilim_reg <= ilim_next;
      ccref_reg <= ccref_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // RULE_09: bleed levels, control kept
  assign weak_bleed_out = in_ctl && sense_in.fb_above_2pct;
  assign strong_bleed_out = in_ctl && sense_in.fb_above_10pct;
  // RULE_15: sense compare
  assign cc_limit_out = isense_over_in && !isense_grounded_in;
  assign request_out = req_reg;
  assign retry_cmd_out = retry_reg;
  assign in_control_out = in_ctl;
  assign sync_rect_gate_out = gate_reg;
  assign ilim_pct_out = ilim_reg;
  assign cc_ref_pct_out = ccref_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_gate_low;
    @(posedge core_clk_in) disable iff (rst_in)
      !in_ctl |-> !sync_rect_gate_out;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate high"); // RULE_16

  property p_single;
    @(posedge core_clk_in) disable iff (rst_in)
      request_out |=> !request_out;
  endproperty
  a_single: assert property (p_single) else $error("double req"); // RULE_25

  property p_gate_off_req;
    @(posedge core_clk_in) disable iff (rst_in)
      request_out |-> !sync_rect_gate_out;
  endproperty
  a_gate_off_req: assert property (p_gate_off_req) else $error("gate on"); // RULE_24

  property p_open_stop;
    @(posedge core_clk_in) disable iff (rst_in)
      open_reg |-> !request_out;
  endproperty
  a_open_stop: assert property (p_open_stop) else $error("open req"); // RULE_18

  property p_blocked;
    @(posedge core_clk_in) disable iff (rst_in)
      request_out |=> !request_out [*7];
  endproperty
  a_blocked: assert property (p_blocked) else $error("on-time req"); // RULE_07

  property p_ilim;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_reg == SCREQ_RAMP) |=> (ilim_pct_out == 8'd75);
  endproperty
  a_ilim: assert property (p_ilim) else $error("ilim cap"); // RULE_02

  property p_fold;
    @(posedge core_clk_in) disable iff (rst_in)
      sense_in.hot_die |=> (cc_ref_pct_out < 8'd100);
  endproperty
  a_fold: assert property (p_fold) else $error("no foldback"); // RULE_08

  property p_ovp;
    @(posedge core_clk_in) disable iff (rst_in)
      (in_ctl && !retry_done_reg && sense_in.fb_above_20pct)
        |=> retry_cmd_out ##1 !in_ctl;
  endproperty
  a_ovp: assert property (p_ovp) else $error("no retry"); // RULE_10
endmodule

// File: screq_defines.svh
/*
 * Timing constants, fixed points and reset values for the secondary
 * cycle request controller.
 * Assumes a 200 MHz core clock; included by the screq_ctrl module only.
 */
`ifndef SCREQ_DEFINES_SVH
`define SCREQ_DEFINES_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define SCREQ_CLK_MHZ 200

// ****************************************************************
// Times in their own units and derived cycle counts
// ****************************************************************
// Longest wait for the winding-sense falling edge, in us
`define SCREQ_ONTIME_TMO_US 30
`define SCREQ_ONTIME_TMO_CYC (`SCREQ_ONTIME_TMO_US * `SCREQ_CLK_MHZ)
// Edge blanking after a request, in ns (least time, rounds up)
`define SCREQ_BLANK_NS 1000
`define SCREQ_BLANK_CYC ((`SCREQ_BLANK_NS * `SCREQ_CLK_MHZ + 999) / 1000)
// Feedback short deglitch, below 10 us: 8 us chosen
`define SCREQ_SHORT_DGL_NS 8000
`define SCREQ_SHORT_DGL_CYC (`SCREQ_SHORT_DGL_NS * `SCREQ_CLK_MHZ / 1000)
// Valley window active time, in us
`define SCREQ_VALLEY_US 20
`define SCREQ_VALLEY_CYC (`SCREQ_VALLEY_US * `SCREQ_CLK_MHZ)
// Soft-start reference request rate, in kHz
`define SCREQ_SOFT_KHZ 100
`define SCREQ_SOFT_CYC (`SCREQ_CLK_MHZ * 1000 / `SCREQ_SOFT_KHZ)

// ****************************************************************
// Fixed levels
// ****************************************************************
// Current limit during start-up, percent of maximum
`define SCREQ_SOFT_ILIM_PCT 8'd75
// Constant-current limit, full and thermally folded back (percent)
`define SCREQ_CC_FULL_PCT 8'd100
`define SCREQ_CC_FOLD_PCT 8'd70

`endif

// File: screq_pkg.sv
/*
 * Types shared by the cycle request controller.
 * Assumes screq_defines.svh sits in the include path.
 */
package screq_pkg;

  // ****************************************************************
  // Qualified analog flags, already synchronous to the core clock
  // ****************************************************************
  typedef struct packed {
    logic fb_above_2pct;   // Feedback 2 % above regulation
    logic fb_above_10pct;  // Feedback 10 % above regulation
    logic fb_above_20pct;  // Feedback 20 % above regulation
    logic fb_in_reg;       // Output has reached regulation
    logic fb_short;        // Feedback below the short level
    logic vout_low;        // Output below output_retry_level
    logic supply_ovc;      // Supply current over its level
    logic hot_die;         // Die at 124 C or above
    logic dcm_seen;        // Discontinuous mode or 2 V ringing
    logic valley;          // Minimum primary switch voltage window
    logic ccm;             // Continuous conduction mode
  } screq_sense_t;

  // ****************************************************************
  // Controller phases, Gray coded along start-up path
  // ****************************************************************
  typedef enum logic [2:0] {
    SCREQ_IDLE  = 3'b000,
    SCREQ_SHAKE = 3'b001,
    SCREQ_RAMP  = 3'b011,
    SCREQ_RUN   = 3'b010,
    SCREQ_STOP  = 3'b110
  } screq_state_t;

endpackage

// File: screq_timer.sv
/*
 * Down-counting timer with load and expiry flag.
 * Assumes the same core clock and synchronous reset as its user.
 */
`timescale 1ns/10ps
module screq_timer #(
  parameter int W = 24
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic done_out
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  // Count down, flag stays until the next load
  always_comb begin
    cnt_next = cnt_reg;
    done_next = done_reg;
    if (load_in) begin
      cnt_next = value_in;
      done_next = 1'b0;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
      done_next = (cnt_reg == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done_out = done_reg;
endmodule

// File: screq_primary_model.sv
/*
 * Behavioural primary-side switch controller facing the request link.
 * Assumes the same core clock and synchronous reset as the controller.
 */
`timescale 1ns/10ps
module screq_primary_model #(
  parameter int ON_CYC = 300,    // Primary on-time, past edge blanking
  parameter int ABS_CYC = 8000   // request_absence_timeout, shortened
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic request_in,   // Cycle request from the secondary
  input wire logic stall_in,     // Hold on-time: no falling edge at all
  output logic winding_sense_out,
  output logic retry_seen_out    // Primary fell into fault retry
);
  // ****************************************************************
  // Primary conduction and request absence
  // ****************************************************************
  int on_cnt;   // Remaining on-time cycles
  int abs_cnt;  // Cycles since the last request

  // Each request starts one conduction; winding falls when it ends
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      winding_sense_out <= 1'b0;
      on_cnt <= 0;
      abs_cnt <= 0;
      retry_seen_out <= 1'b0;
    end else if (request_in) begin
      winding_sense_out <= 1'b1;
      on_cnt <= ON_CYC;
      abs_cnt <= 0;
    end else begin
      // A stalled primary never shows the edge, so the timeout is hit
      if (on_cnt > 1) begin
        on_cnt <= on_cnt - 1;
      end else if (on_cnt == 1 && !stall_in) begin
        winding_sense_out <= 1'b0;
        on_cnt <= 0;
      end
      abs_cnt <= abs_cnt + 1;
      if (abs_cnt > ABS_CYC) begin
        retry_seen_out <= 1'b1;
      end
    end
  end
endmodule

// File: secondary_cycle_request_control_bench.sv
/*
 * Self-checking bench for the cycle request controller, one task each.
 * Assumes the design files and the primary model compile before it.
 */
`timescale 1ns/10ps
module secondary_cycle_request_control_bench;
  import screq_pkg::*;
  // ****************************************************************
  // Stimulus, design and partner
  // ****************************************************************
  logic clk = 0, rst = 1, en = 0, hs = 0, cap = 1, gnd = 0;
  logic igr = 0, iov = 0, stall = 0;
  screq_sense_t sn = '0;
  logic req, rty, ctl, gate, wb, sb, ccl, ws, absent;
  logic [7:0] ilim, ccr;
  int errors = 0, check_count = 0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  // Short ramp and timers keep the run brief
  screq_ctrl #(.RAMP_CYC(4000), .RETRY_CYC(20000), .UV_CYC(2000))
    screq_ctrl_i (.core_clk_in(clk), .rst_in(rst), .enable_in(en),
    .handshake_done_in(hs), .sense_in(sn), .winding_sense_in(ws),
    .gate_cap_big_in(cap), .gate_grounded_in(gnd),
    .isense_grounded_in(igr), .isense_over_in(iov), .request_out(req),
    .retry_cmd_out(rty), .in_control_out(ctl), .sync_rect_gate_out(gate),
    .weak_bleed_out(wb), .strong_bleed_out(sb), .ilim_pct_out(ilim),
    .cc_ref_pct_out(ccr), .cc_limit_out(ccl));
  screq_primary_model screq_primary_model_i (.core_clk_in(clk),
    .rst_in(rst), .request_in(req), .stall_in(stall),
    .winding_sense_out(ws), .retry_seen_out(absent));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("ERROR t=%0t got=%h range=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Bounded wait for a request; n is the count of cycles waited
  task automatic wait_req(input int lim, output int n);
    n = 0;
    while (req !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (req === 1'b1) begin
      chk(gate, 1'b0);
      tick(1);
      chk(req, 1'b0);
    end
  endtask

  // Reset, then enable and handshake; straps settle after reset release
  task automatic start(input logic big, input logic grounded);
    rst = 1;
    en = 0;
    sn = '0;
    stall = 0;
    cap = big;
    gnd = grounded;
    tick(6);
    chk(ctl, 1'b0);
    chk({req, rty, gate, ilim, ccr}, {3'b000, 8'd75, 8'd100});
    rst = 0;
    // Straps need two edges through their synchronisers
    tick(2);
    en = 1;
    tick(1);
    hs = 1;
    tick(1);
    hs = 0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_ramp();
    int n;
    start(1, 0);
    chk({ctl, ilim}, {1'b1, 8'd75});
    wait_req(2100, n);
    chk_in(n, 1700, 2000);
    wait_req(2500, n);
    chk_in(n + 1, 1550, 1620);
    tick(4000);
    wait_req(2000, n);
    wait_req(2000, n);
    chk_in(n + 1, 1500, 1520);
    chk(ilim, 8'd100);
    stall = 1;
    wait_req(7000, n);
    chk_in(n + 1, 6000, 6500);
    wait_req(7000, n);
    chk_in(n + 1, 6000, 6500);
  endtask

  // Over-voltage and supply overcurrent each send one retry
  task automatic t_retry();
    for (int i = 0; i < 2; i++) begin
      start(1, 0);
      sn.supply_ovc = (i == 1);
      sn.fb_above_20pct = (i == 0);
      tick(1);
      chk(rty, 1'b1);
      tick(1);
      chk(rty, 1'b0);
    end
  endtask

  task automatic t_levels();
    start(1, 0);
    sn.fb_above_2pct = 1;
    tick(1);
    chk({wb, sb}, 2'b10);
    sn.fb_above_10pct = 1;
    tick(1);
    chk({wb, sb, ctl}, 3'b111);
    sn.hot_die = 1;
    iov = 1;
    tick(2);
    chk({ccr, ccl}, {8'd70, 1'b1});
    igr = 1;
    tick(1);
    chk(ccl, 1'b0);
    igr = 0;
    iov = 0;
  endtask

  // Open pin starves the primary; grounded pin keeps requests, no drive
  task automatic t_gate_pin();
    int n;
    start(0, 0);
    tick(4000);
    wait_req(9000, n);
    chk(n, 9000);
    chk(absent, 1'b1);
    start(0, 1);
    wait_req(2100, n);
    chk_in(n, 1700, 2000);
    tick(600);
    chk(gate, 1'b0);
  endtask

  // Short masked through the ramp, then stops all requests after deglitch, control kept
  task automatic t_short();
    int n;
    start(1, 0);
    sn.fb_short = 1;
    wait_req(10, n);
    wait_req(2100, n);
    chk_in(n, 0, 2099);
    tick(4000);
    wait_req(6000, n);
    chk(n, 6000);
    chk({ctl, req}, 2'b10);
  endtask

  task automatic t_valley();
    int n;
    start(1, 0);
    tick(4100);
    sn.dcm_seen = 1;
    tick(1);
    sn.dcm_seen = 0;
    wait_req(3900, n);
    chk(n, 3900);
    wait_req(2000, n);
    chk_in(n, 0, 1999);
  endtask

  task automatic t_undervolt();
    start(1, 0);
    tick(4100);
    sn.vout_low = 1;
    tick(1900);
    chk(ctl, 1'b1);
    chk(gate, 1'b1);
    tick(200);
    chk(ctl, 1'b0);
    chk(gate, 1'b0);
  endtask

  // ****************************************************************
  // Verdict and sequencing
  // ****************************************************************
  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // About forty percent over the expected run length
  initial begin
    #450000;
    errors++;
    close_out();
  end

  initial begin
    t_ramp();
    t_retry();
    t_levels();
    t_gate_pin();
    t_short();
    t_valley();
    t_undervolt();
    close_out();
  end
endmodule
